// ==== rtl/camera_capture_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "csi_capture_defines.svh"

module camera_capture_port (
  input wire logic clk, // System clock, 40 MHz
  input wire logic reset_n, // Asynchronous reset
  input wire logic pix_clk, // Sensor pixel clock
  input wire logic frame_sync, // Sensor frame sync
  input wire logic line_sync, // Sensor line sync
  input wire logic [`CSI_DATA_W-1:0] pix_data, // Sensor pixel bus
  input wire logic gated_mode, // 1 = gated, 0 = non-gated
  input wire logic latch_falling, // 1 = latch on falling pixel edge
  input wire logic frame_sync_falling, // 1 = frame starts on falling edge
  output logic pixel_valid, // One-cycle pixel strobe
  output csi_capture_pkg::pixel_t pixel, // Pixel with frame/line flags
  output logic frame_start, // One-cycle frame start pulse
  output logic frame_active, // A frame start has been seen
  output logic line_active, // Synchronised line sync, gated only
  output logic sync_gap_error // Data came too soon after frame edge
);

  // ----------------------------------------
  // Pixel clock domain: reset and settings
  // ----------------------------------------
  logic [1:0] pix_rst_q;
  logic [1:0] pix_gated_q;
  logic [1:0] pix_fall_q;
  logic pix_rst_n;

  // Reset asserts at once, releases on the pixel clock
  always_ff @(posedge pix_clk or negedge reset_n)
  begin
    if (!reset_n)
      pix_rst_q <= `CSI_SYNC_RST;
    else
      pix_rst_q <= {pix_rst_q[0], 1'b1};
  end

  assign pix_rst_n = pix_rst_q[1];

  // Settings are quasi-static; change them only between frames
  always_ff @(posedge pix_clk or negedge pix_rst_n)
  begin
    if (!pix_rst_n)
    begin
      pix_gated_q <= `CSI_SYNC_RST;
      pix_fall_q <= `CSI_SYNC_RST;
    end
    else
    begin
      pix_gated_q <= {pix_gated_q[0], gated_mode};
      pix_fall_q <= {pix_fall_q[0], latch_falling};
    end
  end

  // ----------------------------------------
  // Pixel clock domain: capture
  // ----------------------------------------
  // Two slots per edge: a word stays put for two pixel periods,
  // long enough for the toggle to cross and the word to be read.
  csi_capture_pkg::cap_word_t rise_slot [2];
  csi_capture_pkg::cap_word_t fall_slot [2];
  logic rise_tog;
  logic fall_tog;
  logic rise_line_prev;
  logic fall_line_prev;
  logic rise_take;
  logic fall_take;

  assign rise_take = !pix_fall_q[1] && (!pix_gated_q[1] || line_sync);
  assign fall_take = pix_fall_q[1] && (!pix_gated_q[1] || line_sync);

  always_ff @(posedge pix_clk or negedge pix_rst_n)
  begin
    if (!pix_rst_n)
    begin
      rise_tog <= 1'b0;
      rise_line_prev <= 1'b0;
      rise_slot[0] <= '0;
      rise_slot[1] <= '0;
    end
    else
    begin
      rise_line_prev <= line_sync;
      if (rise_take)
      begin
        rise_slot[rise_tog].sol <= pix_gated_q[1] && !rise_line_prev;
        rise_slot[rise_tog].data <= pix_data;
        rise_tog <= !rise_tog;
      end
    end
  end

  always_ff @(negedge pix_clk or negedge pix_rst_n)
  begin
    if (!pix_rst_n)
    begin
      fall_tog <= 1'b0;
      fall_line_prev <= 1'b0;
      fall_slot[0] <= '0;
      fall_slot[1] <= '0;
    end
    else
    begin
      fall_line_prev <= line_sync;
      if (fall_take)
      begin
        fall_slot[fall_tog].sol <= pix_gated_q[1] && !fall_line_prev;
        fall_slot[fall_tog].data <= pix_data;
        fall_tog <= !fall_tog;
      end
    end
  end

  // ----------------------------------------
  // System clock domain: synchronisers
  // ----------------------------------------
  logic [1:0] fs_q;
  logic [1:0] ls_q;
  logic [1:0] rtog_q;
  logic [1:0] ftog_q;
  logic fs_d;
  logic ls_d;
  logic rtog_d;
  logic ftog_d;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fs_q <= `CSI_SYNC_RST;
      ls_q <= `CSI_SYNC_RST;
      rtog_q <= `CSI_SYNC_RST;
      ftog_q <= `CSI_SYNC_RST;
    end
    else
    begin
      fs_q <= {fs_q[0], frame_sync};
      ls_q <= {ls_q[0], line_sync};
      rtog_q <= {rtog_q[0], rise_tog};
      ftog_q <= {ftog_q[0], fall_tog};
    end
  end

  // History stage, read only from the second flip-flop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fs_d <= 1'b0;
      ls_d <= 1'b0;
      rtog_d <= 1'b0;
      ftog_d <= 1'b0;
    end
    else
    begin
      fs_d <= fs_q[1];
      ls_d <= ls_q[1];
      rtog_d <= rtog_q[1];
      ftog_d <= ftog_q[1];
    end
  end

  // ----------------------------------------
  // System clock domain: events
  // ----------------------------------------
  logic frame_edge;
  logic pix_evt;
  logic line_rise;
  csi_capture_pkg::cap_word_t evt_word;

  assign frame_edge = frame_sync_falling ? (fs_d && !fs_q[1]) : (!fs_d && fs_q[1]);
  assign line_rise = gated_mode && ls_q[1] && !ls_d;
  assign pix_evt = latch_falling ? (ftog_q[1] ^ ftog_d) : (rtog_q[1] ^ rtog_d);
  assign evt_word = latch_falling ? fall_slot[!ftog_q[1]] : rise_slot[!rtog_q[1]];

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  csi_capture_pkg::frame_state_t state;
  csi_capture_pkg::frame_state_t next_state;
  logic sof_pending;

  always_comb
  begin
    next_state = state;
    case (state)
      csi_capture_pkg::FS_WAIT:
        if (frame_edge)
          next_state = csi_capture_pkg::FS_ACTIVE;
      csi_capture_pkg::FS_ACTIVE:
        next_state = csi_capture_pkg::FS_ACTIVE;
      default:
        next_state = csi_capture_pkg::FS_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= csi_capture_pkg::FS_WAIT;
    else
      state <= next_state;
  end

  // A frame edge in the same cycle as a pixel wins over the clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sof_pending <= 1'b0;
    else if (frame_edge)
      sof_pending <= 1'b1;
    else if (pix_evt)
      sof_pending <= 1'b0;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pixels before the first frame edge are dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pixel_valid <= 1'b0;
      pixel <= '0;
    end
    else
    begin
      pixel_valid <= pix_evt && (state == csi_capture_pkg::FS_ACTIVE);
      if (pix_evt)
        pixel <= {sof_pending, evt_word.sol, evt_word.data};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_start <= 1'b0;
      frame_active <= 1'b0;
      line_active <= 1'b0;
    end
    else
    begin
      frame_start <= frame_edge;
      frame_active <= (next_state == csi_capture_pkg::FS_ACTIVE);
      line_active <= gated_mode && ls_q[1];
    end
  end

  // ----------------------------------------
  // Frame-edge to data spacing check
  // ----------------------------------------
  logic [3:0] gap_cnt;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gap_cnt <= `CSI_GAP_RST;
    else if (frame_edge)
      gap_cnt <= `CSI_GAP_START;
    else if (gap_cnt < `CSI_SYNC_GAP_CYC)
      gap_cnt <= gap_cnt + 4'h1;
  end

  // Sticky for the rest of the frame; a new frame edge re-arms it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sync_gap_error <= 1'b0;
    else if (frame_edge)
      sync_gap_error <= 1'b0;
    else if ((state == csi_capture_pkg::FS_ACTIVE) && (gap_cnt < `CSI_SYNC_GAP_CYC)
             && (gated_mode ? line_rise : pix_evt))
      sync_gap_error <= 1'b1;
  end

endmodule

`default_nettype wire

// ==== rtl/csi_capture_defines.svh ====
// Notes on behaviour
// - Gated mode uses frame, line and pixel clock; chosen frame edge starts frame.
// - Gated mode: pixel edges count only while line sync is high.
// - Port latches on rising edge when sensor launches on falling, both modes.
// - Non-gated mode uses only frame sync and pixel clock; line sync ignored.
`ifndef CSI_CAPTURE_DEFINES_SVH
`define CSI_CAPTURE_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CSI_DATA_W 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSI_CLK_PERIOD_NS 25
`define CSI_SYNC_GAP_THCLK 9
`define CSI_SYNC_GAP_CYC 4'h9
// Count loaded on a frame edge, so the count equals cycles since the edge
`define CSI_GAP_START 4'h1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSI_SYNC_RST 2'h0
`define CSI_GAP_RST 4'h0

`endif

// ==== rtl/csi_capture_pkg.sv ====
`default_nettype none
`include "csi_capture_defines.svh"

package csi_capture_pkg;

  // Word as latched at the pixel clock
  typedef struct packed {
    logic sol;
    logic [`CSI_DATA_W-1:0] data;
  } cap_word_t;

  // Word as delivered in the system clock domain
  typedef struct packed {
    logic sof;
    logic sol;
    logic [`CSI_DATA_W-1:0] data;
  } pixel_t;

  typedef enum logic [1:0] {
    FS_WAIT = 2'b01,
    FS_ACTIVE = 2'b10
  } frame_state_t;

endpackage

`default_nettype wire

// ==== tb/capture_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module capture_sva (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic frame_sync, // Frame
  input wire logic line_sync, // Line
  input wire logic gated_mode, // Mode
  input wire logic frame_sync_falling, // Edge
  input wire logic pixel_valid, // Strobe
  input wire logic frame_start, // Pulse
  input wire logic frame_active, // Level
  input wire logic line_active // Level
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence fs_edge;
    frame_sync_falling ? $fell(frame_sync) : $rose(frame_sync);
  endsequence
  // Two flops plus output flop fit well inside five samples
  sequence line_hi;
    (gated_mode && line_sync)[*5];
  endsequence
  AST_FRAME_LAT: assert property (fs_edge |-> ##[2:5] frame_start)
    else $error("frame start late");
  AST_FS_ONE: assert property (frame_start |=> !frame_start)
    else $error("frame start too long");
  AST_ACT_HOLD: assert property (frame_active |=> frame_active)
    else $error("frame active dropped");
  AST_PV_FRAME: assert property (pixel_valid |-> frame_active)
    else $error("pixel before frame");
  AST_PV_ONE: assert property (pixel_valid |=> !pixel_valid)
    else $error("pixel strobe too long");
  AST_LINE_ON: assert property (line_hi |-> line_active)
    else $error("line not seen");
  AST_LINE_OFF: assert property ((gated_mode && !line_sync)[*5] |-> !line_active)
    else $error("line seen while low");
  AST_NONGATED: assert property ((!gated_mode)[*5] |-> !line_active)
    else $error("line used in non-gated mode");
endmodule
bind camera_capture_port capture_sva capture_sva_i (.clk, .reset_n, .frame_sync,
  .line_sync, .gated_mode, .frame_sync_falling, .pixel_valid, .frame_start,
  .frame_active, .line_active);
`default_nettype wire

// ==== tb/sensor_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sensor_model (
  output logic pix_clk, // Pixel clock
  output logic frame_sync, // Frame
  output logic line_sync, // Line
  output logic [7:0] pix_data, // Pixels
  input wire logic latch_falling // Port edge
);
  // ----
  // Sensor
  // ----
  // Slightly over one clk so the phase drifts against clk
  localparam realtime HALF = 25.7;
  initial
  begin
    pix_clk = 1'b0;
    frame_sync = 1'b0;
    line_sync = 1'b0;
    pix_data = 8'h00;
  end
  task automatic frame_edge(input logic fall, input int gap);
    // Keep sync edges off the clk edge to avoid a sampling race
    #7;
    frame_sync = fall;
    #125;
    frame_sync = !fall;
    #(gap * 25);
  endtask
  // Pixel clock stands still low outside lines
  task automatic run(input int n, input logic [7:0] b, input logic hs);
    line_sync = hs;
    for (int i = 0; i < n; i++)
    begin
      if (!latch_falling)
        pix_data = b + 8'(i);
      #HALF pix_clk = 1'b1;
      if (latch_falling)
        pix_data = b + 8'(i);
      #HALF pix_clk = 1'b0;
    end
    #HALF line_sync = 1'b0;
    pix_data = ~pix_data;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic gated_mode = 1'b0;
  logic latch_falling = 1'b1;
  logic frame_sync_falling = 1'b1;
  logic pix_clk, frame_sync, line_sync, pixel_valid, frame_start, frame_active;
  logic line_active, sync_gap_error;
  logic [7:0] pix_data;
  csi_capture_pkg::pixel_t pixel;
  csi_capture_pkg::pixel_t got[$];
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  camera_capture_port camera_capture_port_i (.clk, .reset_n, .pix_clk, .frame_sync,
    .line_sync, .pix_data, .gated_mode, .latch_falling, .frame_sync_falling, .pixel_valid,
    .pixel, .frame_start, .frame_active, .line_active, .sync_gap_error);
  sensor_model sensor_model_i (.pix_clk, .frame_sync, .line_sync, .pix_data, .latch_falling);
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (pixel_valid === 1'b1)
      got.push_back(pixel);
    if (cycles == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // ----
  // Helpers
  // ----
  // Idle pixel clocks let the modes settle; their pixels are thrown away
  task automatic frame(input logic gm, input logic lf, input logic ff, input int gap);
    @(posedge clk);
    gated_mode <= gm;
    latch_falling <= lf;
    frame_sync_falling <= ff;
    repeat (4) @(posedge clk);
    sensor_model_i.run(4, 8'h00, 1'b0);
    repeat (8) @(posedge clk);
    got.delete();
    sensor_model_i.frame_edge(ff, gap);
  endtask
  task automatic line(input int n, input logic [7:0] b, input logic hs, input logic f,
    input logic l, input int k);
    sensor_model_i.run(n, b, hs);
    repeat (8) @(posedge clk);
    chk(10'(got.size()), 10'(k));
    foreach (got[i])
      chk(got[i], {f && i == 0, l && i == 0, b + 8'(i)});
    got.delete();
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_nongated;
    frame(1'b0, 1'b1, 1'b1, 12);
    chk(10'(frame_active), 10'h1);
    line(4, 8'h10, 1'b0, 1'b1, 1'b0, 4);
    line(3, 8'h20, 1'b1, 1'b0, 1'b0, 3);
  endtask
  task automatic t_gated;
    frame(1'b1, 1'b0, 1'b0, 12);
    line(3, 8'h40, 1'b1, 1'b1, 1'b1, 3);
    line(3, 8'h50, 1'b0, 1'b0, 1'b0, 0);
    line(2, 8'hfe, 1'b1, 1'b0, 1'b1, 2);
    chk(10'(sync_gap_error), 10'h0);
  endtask
  task automatic t_gap;
    frame(1'b1, 1'b1, 1'b0, 3);
    sensor_model_i.run(2, 8'h60, 1'b1);
    repeat (4) @(posedge clk);
    chk(10'(sync_gap_error), 10'h1);
    frame(1'b1, 1'b1, 1'b0, 12);
    line(2, 8'h70, 1'b1, 1'b1, 1'b1, 2);
    chk(10'(sync_gap_error), 10'h0);
  endtask
  initial
  begin
    fork
      sensor_model_i.run(2, 8'h00, 1'b0);
      repeat (6) @(posedge clk);
    join
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_nongated();
    t_gated();
    t_gap();
    wrap_up();
  end
endmodule
`default_nettype wire
